// ### logic/trc_control_unit.sv
// Control core of the tag reader: command decode, duplicate filter,
// reports, RF enable and sense outputs.
// Assumes the serial framer hands over decoded commands as one-cycle strobes.
`timescale 1ns/1ps
`default_nettype none
module trc_control_unit import trc_pkg::*; #(
  parameter int ID_W = 32,
  parameter logic [UNIQ_W-1:0] UNIQ_CYC = UNIQ_W'(UNIQ_CYC_DEF),
  parameter logic [PULSE_W-1:0] PULSE_UNIT_CYC = PULSE_W'(PULSE_UNIT_CYC_DEF)
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Host commands
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_op,
  input wire logic [7:0] cmd_arg,
  // Tag decoder
  input wire logic tag_valid,
  input wire logic [ID_W-1:0] tag_id,
  // Sense lines and events
  input wire logic presence_sense_line,
  input wire logic auxiliary_sense_line,
  input wire logic presence_fitted,
  input wire logic power_fail_evt,
  // Reports to host
  output logic rpt_valid,
  output logic [1:0] rpt_kind,
  output logic [ID_W-1:0] rpt_data,
  // RF transmitter
  output logic rf_enable,
  output logic rf_cw,
  // Sense outputs
  output logic first_signal_output,
  output logic second_signal_output,
  // Status
  output logic data_mode,
  output logic power_fail_flag,
  output logic tx_all_mode,
  output logic sep_two,
  output logic [7:0] freq_code,
  output logic presence_rpt_code,
  output logic change_rpt_en_code,
  output logic [1:0] change_mask_code,
  output logic out_src_code,
  output logic [1:0] out_state_code,
  output logic [1:0] in_state_code
);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  function automatic logic fn_match(input logic vld, input logic [ID_W-1:0] a,
                                    input logic [ID_W-1:0] b);
    fn_match = vld && (a == b);
  endfunction

  // ------------------------------------------------------------
  // Configuration
  // ------------------------------------------------------------
  logic data_mode_ff, nxt_data_mode;
  logic tx_all_ff, nxt_tx_all;
  logic sep_two_ff, nxt_sep_two;
  logic pres_rpt_ff, nxt_pres_rpt;
  logic [1:0] mask_ff, nxt_mask;
  logic [7:0] freq_ff, nxt_freq;
  trc_rf_mode_t rf_mode_ff, nxt_rf_mode;
  logic invert_ff, nxt_invert;
  logic wieg_ff, nxt_wieg;
  logic out_auto_ff, nxt_out_auto;
  logic [1:0] out_host_ff, nxt_out_host;
  logic [3:0] digit_ff, nxt_digit;
  logic pfail_ff, nxt_pfail;
  logic is_reset;

  assign is_reset = cmd_valid && (cmd_op == OP_RESET);

  always_comb begin
    nxt_data_mode = data_mode_ff;
    nxt_tx_all = tx_all_ff;
    nxt_sep_two = sep_two_ff;
    nxt_pres_rpt = pres_rpt_ff;
    nxt_mask = mask_ff;
    nxt_freq = freq_ff;
    nxt_rf_mode = rf_mode_ff;
    nxt_invert = invert_ff;
    nxt_wieg = wieg_ff;
    nxt_out_auto = out_auto_ff;
    nxt_out_host = out_host_ff;
    nxt_digit = digit_ff;
    nxt_pfail = pfail_ff;
    if (cmd_valid) begin
      case (cmd_op)
        OP_DATA_MODE: nxt_data_mode = 1'b1;
        OP_CMD_MODE: nxt_data_mode = 1'b0;
        OP_TX_ALL: nxt_tx_all = 1'b1; // R3
        OP_SEPARATION: begin
          if (cmd_arg <= ARG_ON) begin
            nxt_sep_two = (cmd_arg == ARG_ON); // R1
            nxt_tx_all = 1'b0; // R4
          end
        end
        OP_PRESENCE_RPT: begin
          if (cmd_arg <= ARG_ON) begin
            nxt_pres_rpt = (cmd_arg == ARG_ON); // R6
          end
        end
        OP_CHANGE_RPT: begin
          if (cmd_arg <= ARG_MASK_MAX) begin
            nxt_mask = cmd_arg[1:0]; // R9
          end
        end
        OP_RESET: begin
          nxt_data_mode = 1'b1; // R11
          nxt_pfail = 1'b0; // R11
        end
        OP_FREQ: begin
          if (cmd_arg <= FREQ_CODE_MAX) begin
            nxt_freq = cmd_arg; // R12
          end
        end
        OP_RF_CTRL: begin
          case (cmd_arg)
            ARG_OFF: nxt_rf_mode = RF_HOST_OFF; // R15
            ARG_ON: nxt_rf_mode = RF_HOST_ON; // R15
            ARG_CW: nxt_rf_mode = RF_CW; // R16
            default: nxt_rf_mode = rf_mode_ff;
          endcase
        end
        OP_RF_BY_INPUT: nxt_rf_mode = RF_BY_INPUT; // R14
        OP_INVERT: begin
          if (cmd_arg <= ARG_ON) begin
            nxt_invert = (cmd_arg == ARG_ON); // R19
          end
        end
        OP_OUT_SET: begin
          if (cmd_arg <= ARG_MASK_MAX) begin
            nxt_out_auto = 1'b0; // R22
            nxt_out_host = {cmd_arg[0], cmd_arg[1]}; // R22
          end
        end
        OP_OUT_AUTO: nxt_out_auto = 1'b1; // R20
        OP_PULSE_LEN: begin
          if (cmd_arg <= ARG_DIGIT_MAX) begin
            nxt_digit = cmd_arg[3:0]; // R21
          end
        end
        OP_WIEGAND: begin
          if (cmd_arg <= ARG_ON) begin
            nxt_wieg = (cmd_arg == ARG_ON);
          end
        end
        default: nxt_data_mode = data_mode_ff;
      endcase
    end
    // Event arriving with the reset command still wins
    if (power_fail_evt) begin
      nxt_pfail = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      data_mode_ff <= 1'b1;
      tx_all_ff <= 1'b0;
      sep_two_ff <= 1'b0;
      pres_rpt_ff <= PRESENCE_REPORT_OFF_CODE;
      mask_ff <= 2'h0;
      freq_ff <= DEF_FREQ_CODE;
      rf_mode_ff <= RF_BY_INPUT;
      invert_ff <= 1'b0;
      wieg_ff <= 1'b0;
      out_auto_ff <= 1'b1;
      out_host_ff <= 2'h0;
      digit_ff <= DEF_PULSE_DIGIT;
      pfail_ff <= 1'b0;
    end else begin
      data_mode_ff <= nxt_data_mode;
      tx_all_ff <= nxt_tx_all;
      sep_two_ff <= nxt_sep_two;
      pres_rpt_ff <= nxt_pres_rpt;
      mask_ff <= nxt_mask;
      freq_ff <= nxt_freq;
      rf_mode_ff <= nxt_rf_mode;
      invert_ff <= nxt_invert;
      wieg_ff <= nxt_wieg;
      out_auto_ff <= nxt_out_auto;
      out_host_ff <= nxt_out_host;
      digit_ff <= nxt_digit;
      pfail_ff <= nxt_pfail;
    end
  end

  a_sep_select: assert property (cmd_valid && cmd_op == OP_SEPARATION && cmd_arg == ARG_ON
    |=> sep_two_ff && !tx_all_ff) else $error("separation select not applied"); // R4
  a_freq_range: assert property (cmd_valid && cmd_op == OP_FREQ && cmd_arg > FREQ_CODE_MAX
    |=> $stable(freq_ff)) else $error("out of range frequency accepted"); // R12
  a_out_host_set: assert property (cmd_valid && cmd_op == OP_OUT_SET && cmd_arg == 8'h03
    |=> !out_auto_ff && first_signal_output && second_signal_output)
    else $error("output set did not take host control"); // R22

  // ------------------------------------------------------------
  // Duplicate filter
  // ------------------------------------------------------------
  logic [ID_W-1:0] slot_id_ff [2];
  logic [ID_W-1:0] nxt_slot_id [2];
  logic [1:0] slot_vld_ff, nxt_slot_vld;
  logic [UNIQ_W-1:0] slot_age_ff [2];
  logic [UNIQ_W-1:0] nxt_slot_age [2];
  logic tag_ok, dup, fwd;

  // Reads stop during continuous wave
  assign tag_ok = tag_valid && (rf_mode_ff != RF_CW); // R16
  assign dup = !tx_all_ff && (fn_match(slot_vld_ff[0], slot_id_ff[0], tag_id) ||
               (sep_two_ff && fn_match(slot_vld_ff[1], slot_id_ff[1], tag_id))); // R1
  assign fwd = tag_ok && !dup; // R3

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      nxt_slot_id[i] = slot_id_ff[i];
      nxt_slot_vld[i] = slot_vld_ff[i];
      nxt_slot_age[i] = slot_age_ff[i] + 1'b1;
      // Fixed timeout, no command reaches it
      if (slot_age_ff[i] >= UNIQ_CYC - 1'b1) begin
        nxt_slot_vld[i] = 1'b0; // R2
        nxt_slot_age[i] = slot_age_ff[i];
      end
    end
    if (fwd && !tx_all_ff) begin
      if (!(slot_id_ff[0] == tag_id)) begin
        nxt_slot_id[1] = slot_id_ff[0];
        nxt_slot_vld[1] = slot_vld_ff[0] && nxt_slot_vld[0];
        nxt_slot_age[1] = nxt_slot_age[0];
      end
      nxt_slot_id[0] = tag_id;
      nxt_slot_vld[0] = 1'b1;
      nxt_slot_age[0] = '0;
    end
    if (is_reset) begin
      nxt_slot_vld = 2'b00; // R11
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      slot_vld_ff <= 2'b00;
      for (int i = 0; i < 2; i++) begin
        slot_id_ff[i] <= '0;
        slot_age_ff[i] <= '0;
      end
    end else begin
      slot_vld_ff <= nxt_slot_vld;
      slot_id_ff <= nxt_slot_id;
      slot_age_ff <= nxt_slot_age;
    end
  end

  a_uniq_timeout: assert property (slot_vld_ff[0] |-> slot_age_ff[0] < UNIQ_CYC)
    else $error("history outlived uniqueness timeout"); // R2

  // ------------------------------------------------------------
  // Sense inputs, reports and sense outputs
  // ------------------------------------------------------------
  logic [1:0] in_ff, nxt_in, in_prev_ff, nxt_in_prev;
  logic seen_ff, nxt_seen;
  logic rpt_valid_ff, nxt_rpt_valid;
  logic [1:0] rpt_kind_ff, nxt_rpt_kind;
  logic [ID_W-1:0] rpt_data_ff, nxt_rpt_data;
  logic [PULSE_W-1:0] pulse_ff, nxt_pulse;
  logic [1:0] change;
  logic no_tag;

  // Auxiliary line only feeds status and change reports
  assign change = (in_ff ^ in_prev_ff) & mask_ff; // R17
  assign no_tag = presence_fitted && pres_rpt_ff && in_prev_ff[0] && !in_ff[0] &&
                  !seen_ff && data_mode_ff; // R5

  always_comb begin
    nxt_in = {auxiliary_sense_line, presence_sense_line} ^ {2{invert_ff}}; // R19
    nxt_in_prev = in_ff;
    nxt_seen = in_ff[0] ? (seen_ff || tag_ok) : 1'b0;
    nxt_rpt_valid = 1'b1;
    nxt_rpt_kind = RPT_TAG;
    nxt_rpt_data = tag_id;
    // One report a cycle; sign-on outranks reads, then changes
    if (is_reset) begin
      nxt_rpt_kind = RPT_SIGN_ON; // R11
      nxt_rpt_data = '0;
    end else if (fwd) begin
      nxt_rpt_kind = RPT_TAG; // R3
    end else if ((change != 2'h0) && data_mode_ff) begin
      nxt_rpt_kind = RPT_INPUT; // R8
      nxt_rpt_data = ID_W'(in_ff);
    end else if (no_tag) begin
      nxt_rpt_kind = RPT_NO_TAG; // R5
      nxt_rpt_data = '0;
    end else begin
      nxt_rpt_valid = 1'b0;
      nxt_rpt_data = rpt_data_ff;
      nxt_rpt_kind = rpt_kind_ff;
    end
    nxt_pulse = (pulse_ff != '0) ? pulse_ff - 1'b1 : pulse_ff;
    if (fwd && !tx_all_ff && !wieg_ff && out_auto_ff) begin
      nxt_pulse = PULSE_W'((digit_ff + 1'b1) * PULSE_UNIT_CYC); // R21
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      in_ff <= 2'h0;
      in_prev_ff <= 2'h0;
      seen_ff <= 1'b0;
      rpt_valid_ff <= 1'b0;
      rpt_kind_ff <= RPT_TAG;
      rpt_data_ff <= '0;
      pulse_ff <= '0;
    end else begin
      in_ff <= nxt_in;
      in_prev_ff <= nxt_in_prev;
      seen_ff <= nxt_seen;
      rpt_valid_ff <= nxt_rpt_valid;
      rpt_kind_ff <= nxt_rpt_kind;
      rpt_data_ff <= nxt_rpt_data;
      pulse_ff <= nxt_pulse;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign rpt_valid = rpt_valid_ff;
  assign rpt_kind = rpt_kind_ff;
  assign rpt_data = rpt_data_ff;
  assign rf_enable = (rf_mode_ff == RF_BY_INPUT) ? in_ff[0] : // R14
                     (rf_mode_ff == RF_HOST_ON) || (rf_mode_ff == RF_CW); // R15
  assign rf_cw = (rf_mode_ff == RF_CW); // R16
  assign first_signal_output = out_auto_ff ? (pulse_ff != '0) : out_host_ff[0]; // R20
  assign second_signal_output = out_auto_ff ? (pulse_ff != '0) : out_host_ff[1]; // R20
  assign data_mode = data_mode_ff;
  assign power_fail_flag = pfail_ff;
  assign tx_all_mode = tx_all_ff;
  assign sep_two = sep_two_ff;
  assign freq_code = freq_ff; // R13
  assign presence_rpt_code = pres_rpt_ff ? PRESENCE_REPORT_ON_CODE
                                         : PRESENCE_REPORT_OFF_CODE; // R7
  assign change_rpt_en_code = (mask_ff != 2'h0) ? CHANGE_REPORT_ON_CODE
                                                : !CHANGE_REPORT_ON_CODE; // R10
  assign change_mask_code = mask_ff; // R10
  assign out_src_code = out_auto_ff ? OUTPUTS_AUTO_SOURCE_CODE
                                    : OUTPUTS_HOST_SOURCE_CODE; // R18
  assign out_state_code = {second_signal_output, first_signal_output}; // R18
  assign in_state_code = in_ff; // R18

  a_tx_all_fwd: assert property (tag_valid && tx_all_ff && rf_mode_ff != RF_CW && !is_reset
    |=> rpt_valid && rpt_kind == RPT_TAG && rpt_data == $past(tag_id))
    else $error("transmit-all dropped a tag"); // R3
  a_reset_cmd: assert property (is_reset && !power_fail_evt
    |=> rpt_valid && rpt_kind == RPT_SIGN_ON && data_mode && !power_fail_flag
        && slot_vld_ff == 2'b00) else $error("reset command incomplete"); // R11
  a_change_mode: assert property (rpt_valid && rpt_kind == RPT_INPUT
    |-> $past(data_mode_ff) && $past(change) != 2'h0)
    else $error("input report outside data mode"); // R8
  a_no_tag_rpt: assert property (rpt_valid && rpt_kind == RPT_NO_TAG
    |-> $past(pres_rpt_ff) && $past(presence_fitted) && $past(data_mode_ff))
    else $error("no-tag report not enabled"); // R5
  a_rf_input: assert property (rf_mode_ff == RF_BY_INPUT && $rose(in_ff[0]) |-> rf_enable
    ##1 (rf_mode_ff != RF_BY_INPUT || in_ff[0] == rf_enable))
    else $error("rf not following presence"); // R14
  a_rf_host: assert property (cmd_valid && cmd_op == OP_RF_CTRL && cmd_arg == ARG_OFF
    |=> !rf_enable) else $error("rf off ignored"); // R15
  a_cw_hold: assert property (rf_cw && !(cmd_valid && (cmd_op == OP_RF_CTRL ||
    cmd_op == OP_RF_BY_INPUT)) |=> rf_cw && rf_enable) else $error("cw dropped"); // R16
  a_pulse_skip: assert property (pulse_ff == '0 && tag_valid && tx_all_ff
    |=> !first_signal_output || !out_auto_ff) else $error("pulse in transmit-all"); // R20

endmodule
`default_nettype wire

// ### logic/trc_pkg.sv
// Constants and types of the tag reader control unit.
// Assumes one 50 MHz core clock; command, tag and sense inputs are synchronous to it.
//
// Behaviour
// R1 - Host picks one- or two-ID duplicate separation
// R2 - Duplicate timeout fixed at two minutes
// R3 - Transmit-all forwards every tag unfiltered
// R4 - Separation command ends transmit-all, restores filtering
// R5 - Presence without tag reported, data mode only
// R6 - No-tag report default off, on/off commands
// R7 - Presence query shows no-tag report setting
// R8 - Input change reports, data mode, default off
// R9 - Change select: 0 off, 1, 2, 3 both
// R10 - Change query gives enable and mask codes
// R11 - Reset: clear history, power fail; sign on
// R12 - Frequency code 00 to 34, 0.5 MHz steps
// R13 - Frequency query shows current code
// R14 - RF-by-input default: RF follows presence line
// R15 - Host RF off/on overrides presence line
// R16 - Continuous wave suspends reads until RF command
// R17 - Auxiliary input only monitored and reported
// R18 - I/O query: source, output and input codes
// R19 - Input inversion option, default off
// R20 - Auto mode pulses outputs on unique reads
// R21 - Auto pulse length set by digit command
// R22 - Output set moves outputs to host control
package trc_pkg;

  // ------------------------------------------------------------
  // Command operations and arguments
  // ------------------------------------------------------------
  localparam logic [3:0] OP_DATA_MODE = 4'h0;
  localparam logic [3:0] OP_CMD_MODE = 4'h1;
  localparam logic [3:0] OP_TX_ALL = 4'h2;
  localparam logic [3:0] OP_SEPARATION = 4'h3;
  localparam logic [3:0] OP_PRESENCE_RPT = 4'h4;
  localparam logic [3:0] OP_CHANGE_RPT = 4'h5;
  localparam logic [3:0] OP_RESET = 4'h6;
  localparam logic [3:0] OP_FREQ = 4'h7;
  localparam logic [3:0] OP_RF_CTRL = 4'h8;
  localparam logic [3:0] OP_RF_BY_INPUT = 4'h9;
  localparam logic [3:0] OP_INVERT = 4'ha;
  localparam logic [3:0] OP_OUT_SET = 4'hb;
  localparam logic [3:0] OP_OUT_AUTO = 4'hc;
  localparam logic [3:0] OP_PULSE_LEN = 4'hd;
  localparam logic [3:0] OP_WIEGAND = 4'he;

  localparam logic [7:0] ARG_OFF = 8'h00;
  localparam logic [7:0] ARG_ON = 8'h01;
  localparam logic [7:0] ARG_CW = 8'h02;
  localparam logic [7:0] ARG_MASK_MAX = 8'h03;
  localparam logic [7:0] ARG_DIGIT_MAX = 8'h09;
  localparam logic [7:0] FREQ_CODE_MAX = 8'h34;

  // ------------------------------------------------------------
  // Report kinds and status codes
  // ------------------------------------------------------------
  localparam logic [1:0] RPT_TAG = 2'h0;
  localparam logic [1:0] RPT_NO_TAG = 2'h1;
  localparam logic [1:0] RPT_INPUT = 2'h2;
  localparam logic [1:0] RPT_SIGN_ON = 2'h3;
  localparam logic PRESENCE_REPORT_OFF_CODE = 1'b0;
  localparam logic PRESENCE_REPORT_ON_CODE = 1'b1;
  localparam logic CHANGE_REPORT_ON_CODE = 1'b1;
  localparam logic [1:0] CHANGE_MASK_BOTH_CODE = 2'h3;
  localparam logic OUTPUTS_HOST_SOURCE_CODE = 1'b0;
  localparam logic OUTPUTS_AUTO_SOURCE_CODE = 1'b1;

  // ------------------------------------------------------------
  // Reset values and timing
  // ------------------------------------------------------------
  localparam logic [7:0] DEF_FREQ_CODE = 8'h00;
  localparam logic [3:0] DEF_PULSE_DIGIT = 4'h1;
  localparam longint CLK_PERIOD_NS = 20;
  localparam longint UNIQ_TIMEOUT_MS = 120000;
  localparam longint UNIQ_CYC_DEF = UNIQ_TIMEOUT_MS * 64'd1000000 / CLK_PERIOD_NS;
  localparam int UNIQ_W = 36;
  localparam longint PULSE_UNIT_MS = 10;
  localparam longint PULSE_UNIT_CYC_DEF = PULSE_UNIT_MS * 64'd1000000 / CLK_PERIOD_NS;
  localparam int PULSE_W = 24;

  typedef enum logic [1:0] {RF_BY_INPUT, RF_HOST_OFF, RF_HOST_ON, RF_CW} trc_rf_mode_t;

endpackage

// ### tb/trc_host_model.sv
// Host model: issues one decoded command strobe per call of send.
// Assumes the control unit takes a command on the rising edge of core_clk.
`timescale 1ns/1ps
`default_nettype none
module trc_host_model import trc_pkg::*; (
  // Clock
  input wire logic core_clk,
  // Command strobe
  output var logic cmd_valid,
  output var logic [3:0] cmd_op,
  output var logic [7:0] cmd_arg
);
  initial begin
    cmd_valid = 1'b0;
    cmd_op = 4'h0;
    cmd_arg = 8'h00;
  end

  // ----------------------------------------
  // Command transfer
  // ----------------------------------------
  // Idle op and arg show the inverse, so a stale argument is never reused
  task automatic send(input logic [3:0] op, input logic [7:0] arg);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_arg <= arg;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    cmd_op <= ~op;
    cmd_arg <= ~arg;
    @(negedge core_clk);
  endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
// Testbench of the tag reader control unit: commands, tags, sense lines.
// Assumes short duplicate timeout and pulse unit parameters for simulation.
`timescale 1ns/1ps
`default_nettype none
module tb import trc_pkg::*;;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic tag_valid = 1'b0;
  logic [31:0] tag_id = 32'h0;
  logic presence_sense_line = 1'b0;
  logic auxiliary_sense_line = 1'b0;
  logic presence_fitted = 1'b1;
  logic power_fail_evt = 1'b0;
  logic cmd_valid, rpt_valid, rf_enable, rf_cw, first_signal_output, second_signal_output;
  logic data_mode, power_fail_flag, tx_all_mode, sep_two, presence_rpt_code;
  logic change_rpt_en_code, out_src_code;
  logic [3:0] cmd_op;
  logic [7:0] cmd_arg, freq_code;
  logic [1:0] rpt_kind, change_mask_code, out_state_code, in_state_code;
  logic [31:0] rpt_data, last_data;
  logic [1:0] last_kind;
  int num_checks = 0;
  int fail_count = 0;
  int rpt_cnt = 0;
  int hi_cnt = 0;
  int cyc = 0;
  int b;

  always #10 core_clk = ~core_clk;

  trc_host_model trc_host_model_inst (.core_clk, .cmd_valid, .cmd_op, .cmd_arg);

  trc_control_unit #(.UNIQ_CYC(36'd100), .PULSE_UNIT_CYC(24'd4)) trc_control_unit_inst (
    .core_clk, .nrst, .cmd_valid, .cmd_op, .cmd_arg, .tag_valid, .tag_id,
    .presence_sense_line, .auxiliary_sense_line, .presence_fitted, .power_fail_evt,
    .rpt_valid, .rpt_kind, .rpt_data, .rf_enable, .rf_cw, .first_signal_output,
    .second_signal_output, .data_mode, .power_fail_flag, .tx_all_mode, .sep_two,
    .freq_code, .presence_rpt_code, .change_rpt_en_code, .change_mask_code,
    .out_src_code, .out_state_code, .in_state_code);

  // ----------------------------------------
  // Report and pulse monitor, hang limit
  // ----------------------------------------
  always @(posedge core_clk) begin
    cyc++;
    if (rpt_valid === 1'b1) begin
      rpt_cnt++;
      last_kind = rpt_kind;
      last_data = rpt_data;
    end
    if (first_signal_output === 1'b1 && second_signal_output === 1'b1) hi_cnt++;
    if (cyc == 5000) begin
      fail_count++;
      final_report();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic send(input logic [3:0] op, input logic [7:0] arg);
    trc_host_model_inst.send(op, arg);
  endtask

  // Waits long enough for a report registered on the take edge or one edge after it
  task automatic tagx(input logic [31:0] id, input int n);
    b = rpt_cnt;
    @(posedge core_clk);
    tag_valid <= 1'b1;
    tag_id <= id;
    @(posedge core_clk);
    tag_valid <= 1'b0;
    tag_id <= ~id;
    repeat (3) @(negedge core_clk);
    chk("tag reports", rpt_cnt - b, n);
    if (n == 1) chk("tag data", last_data, id);
    if (n == 1) chk("tag kind", last_kind, RPT_TAG);
  endtask

  task automatic setin(input logic p, input logic a);
    @(posedge core_clk);
    presence_sense_line <= p;
    auxiliary_sense_line <= a;
    repeat (4) @(negedge core_clk);
  endtask

  task automatic pulse_chk(input int n);
    repeat (12) @(negedge core_clk);
    chk("pulse cycles", hi_cnt, n);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    @(negedge core_clk);
    chk("separation", sep_two, 1'b0);
    chk("no tag code", presence_rpt_code, PRESENCE_REPORT_OFF_CODE);
    chk("change mask", change_mask_code, 2'h0);
    chk("data mode", data_mode, 1'b1);
    chk("rf enable", rf_enable, 1'b0);
    chk("out source", out_src_code, OUTPUTS_AUTO_SOURCE_CODE);
    $display("test defaults done");
    send(OP_FREQ, 8'h34);
    chk("freq", freq_code, 8'h34);
    send(OP_FREQ, 8'h35);
    chk("freq", freq_code, 8'h34);
    $display("test frequency done");
    hi_cnt = 0;
    tagx(32'ha1, 1);
    pulse_chk(8);
    tagx(32'ha1, 0);
    tagx(32'hb2, 1);
    tagx(32'ha1, 1);
    send(OP_PULSE_LEN, 8'h00);
    // Let the running pulse drain before counting the short one
    repeat (8) @(negedge core_clk);
    hi_cnt = 0;
    tagx(32'hb2, 1);
    pulse_chk(4);
    send(OP_SEPARATION, 8'h01);
    chk("separation", sep_two, 1'b1);
    tagx(32'hc3, 1);
    tagx(32'hd4, 1);
    tagx(32'hc3, 0);
    tagx(32'he5, 1);
    repeat (110) @(negedge core_clk);
    tagx(32'hd4, 1);
    $display("test duplicate filter done");
    send(OP_TX_ALL, 8'h00);
    chk("transmit all", tx_all_mode, 1'b1);
    hi_cnt = 0;
    tagx(32'hd4, 1);
    tagx(32'hd4, 1);
    pulse_chk(0);
    send(OP_SEPARATION, 8'h00);
    chk("transmit all", tx_all_mode, 1'b0);
    tagx(32'hd4, 0);
    $display("test transmit all done");
    @(posedge core_clk);
    power_fail_evt <= 1'b1;
    @(posedge core_clk);
    power_fail_evt <= 1'b0;
    send(OP_CMD_MODE, 8'h00);
    chk("power fail", power_fail_flag, 1'b1);
    b = rpt_cnt;
    send(OP_RESET, 8'h00);
    repeat (3) @(negedge core_clk);
    chk("sign on count", rpt_cnt - b, 1);
    chk("sign on kind", last_kind, RPT_SIGN_ON);
    chk("power fail", power_fail_flag, 1'b0);
    chk("data mode", data_mode, 1'b1);
    chk("freq kept", freq_code, 8'h34);
    tagx(32'hd4, 1);
    $display("test reset command done");
    send(OP_CHANGE_RPT, 8'h03);
    chk("change enable", change_rpt_en_code, CHANGE_REPORT_ON_CODE);
    chk("change mask", change_mask_code, CHANGE_MASK_BOTH_CODE);
    b = rpt_cnt;
    setin(1'b0, 1'b1);
    chk("change count", rpt_cnt - b, 1);
    chk("change kind", last_kind, RPT_INPUT);
    chk("change data", last_data, 32'h2);
    chk("input state", in_state_code, 2'h2);
    chk("rf enable", rf_enable, 1'b0);
    send(OP_CHANGE_RPT, 8'h01);
    b = rpt_cnt;
    setin(1'b0, 1'b0);
    chk("masked change", rpt_cnt - b, 0);
    send(OP_CMD_MODE, 8'h00);
    setin(1'b1, 1'b0);
    chk("command mode change", rpt_cnt - b, 0);
    chk("rf enable", rf_enable, 1'b1);
    setin(1'b0, 1'b0);
    send(OP_DATA_MODE, 8'h00);
    setin(1'b1, 1'b0);
    chk("first input change", last_data, 32'h1);
    send(OP_CHANGE_RPT, 8'h00);
    chk("change enable", change_rpt_en_code, 1'b0);
    b = rpt_cnt;
    setin(1'b0, 1'b0);
    chk("disabled change", rpt_cnt - b, 0);
    $display("test change reports done");
    send(OP_PRESENCE_RPT, 8'h01);
    chk("no tag code", presence_rpt_code, PRESENCE_REPORT_ON_CODE);
    b = rpt_cnt;
    setin(1'b1, 1'b0);
    setin(1'b0, 1'b0);
    chk("no tag count", rpt_cnt - b, 1);
    chk("no tag kind", last_kind, RPT_NO_TAG);
    setin(1'b1, 1'b0);
    tagx(32'hf6, 1);
    b = rpt_cnt;
    setin(1'b0, 1'b0);
    chk("presence with tag", rpt_cnt - b, 0);
    b = rpt_cnt;
    @(posedge core_clk);
    presence_fitted <= 1'b0;
    setin(1'b1, 1'b0);
    setin(1'b0, 1'b0);
    chk("no detector", rpt_cnt - b, 0);
    @(posedge core_clk);
    presence_fitted <= 1'b1;
    send(OP_PRESENCE_RPT, 8'h00);
    chk("no tag code", presence_rpt_code, PRESENCE_REPORT_OFF_CODE);
    $display("test presence reports done");
    setin(1'b1, 1'b0);
    send(OP_RF_CTRL, 8'h00);
    chk("host rf off", rf_enable, 1'b0);
    setin(1'b0, 1'b0);
    send(OP_RF_CTRL, 8'h01);
    chk("host rf on", rf_enable, 1'b1);
    send(OP_RF_CTRL, 8'h02);
    chk("cw flag", rf_cw, 1'b1);
    chk("cw rf", rf_enable, 1'b1);
    tagx(32'h17, 0);
    send(OP_RF_BY_INPUT, 8'h00);
    chk("cw flag", rf_cw, 1'b0);
    chk("rf by input", rf_enable, 1'b0);
    send(OP_INVERT, 8'h01);
    // Sensed state picks up the new polarity one edge after the command
    @(negedge core_clk);
    chk("inverted inputs", in_state_code, 2'h3);
    chk("inverted presence rf", rf_enable, 1'b1);
    send(OP_INVERT, 8'h00);
    @(negedge core_clk);
    chk("inputs", in_state_code, 2'h0);
    $display("test rf and inputs done");
    for (int i = 0; i < 4; i++) begin
      send(OP_OUT_SET, 8'(i));
      chk("second output", second_signal_output, i[0]);
      chk("first output", first_signal_output, i[1]);
      chk("out state", out_state_code, {i[0], i[1]});
      chk("out source", out_src_code, OUTPUTS_HOST_SOURCE_CODE);
    end
    send(OP_OUT_SET, 8'h00);
    hi_cnt = 0;
    tagx(32'h28, 1);
    pulse_chk(0);
    send(OP_OUT_AUTO, 8'h00);
    chk("out source", out_src_code, OUTPUTS_AUTO_SOURCE_CODE);
    send(OP_WIEGAND, 8'h01);
    hi_cnt = 0;
    tagx(32'h39, 1);
    pulse_chk(0);
    $display("test sense outputs done");
    final_report();
  end
endmodule
`default_nettype wire
